// [core/ccg_defs.svh]
/*
 * constants of the condition code generator: flag codes and widths.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef CCG_DEFS_SVH
`define CCG_DEFS_SVH
`define CCG_WORD_W 16
`define CCG_OP_W 3
`define CCG_CC_ZERO 2'h0
`define CCG_CC_MINUS 2'h1
`define CCG_CC_PLUS 2'h2
`define CCG_WORD_ZERO 16'h0000
`define CCG_WORD_MINLIM 16'h8000
`endif

// [core/ccg_pkg.sv]
/*
 * types of the condition code generator: flag-update operation classes and comparison relations.
 * assumes ccg_defs.svh is on the include path.
 */
`include "ccg_defs.svh"
package ccg_pkg;
   // operation class presented with i_op_valid
   typedef enum logic [2:0] {
      CCG_OP_NONE = 3'h0,
      CCG_OP_CMP = 3'h1,
      CCG_OP_ARITH = 3'h2,
      CCG_OP_LOGIC = 3'h3,
      CCG_OP_SHIFT = 3'h4,
      CCG_OP_NEG = 3'h5,
      CCG_OP_ADDK = 3'h6
   } ccg_op_t;
   // comparison relation tested
   typedef enum logic [2:0] {
      CCG_REL_EQ = 3'h0,
      CCG_REL_NE = 3'h1,
      CCG_REL_GT = 3'h2,
      CCG_REL_LT = 3'h3,
      CCG_REL_GE = 3'h4,
      CCG_REL_LE = 3'h5
   } ccg_rel_t;
endpackage : ccg_pkg

// [core/ccg_flags.sv]
/*
 * condition code generator: holds the three flags and the logic result bit,
 * updates them on one operation per cycle and decodes the jump conditions.
 * assumes the datapath presents operands and results on i_mclk, same domain.
 */
// Contract
// RULE1 - compare sets codes equal/less/greater
// RULE2 - compare leaves overflow flag alone
// RULE3 - compare writes result bit from relation
// RULE4 - jump-if-result-set follows result bit
// RULE5 - in-range arithmetic codes sign, clears overflow
// RULE6 - arithmetic overflow codes inverted, sets overflow
// RULE7 - logic op codes zero or nonzero word
// RULE8 - logic op leaves overflow flag alone
// RULE9 - shift codes from last bit out
// RULE10 - shift leaves overflow flag alone
// RULE11 - negate sets all flags from result
// RULE12 - negating 8000 gives minus with overflow
// RULE13 - exactly three flags held
// RULE14 - accumulators are sixteen bits wide
// RULE15 - add constant changes no flag
// RULE16 - jump decode of the flag codes
`timescale 1ns/1ns
`include "ccg_defs.svh"
module ccg_flags
   import ccg_pkg::*;
#(
   parameter int WORD_W = `CCG_WORD_W // RULE14
) (
   input wire logic i_mclk, // processor clock, 50 MHz
   input wire logic i_srst, // synchronous reset, active high
   input wire logic i_op_valid, // one-cycle pulse: operation completes
   input wire ccg_op_t i_op, // operation class
   input wire ccg_rel_t i_rel, // relation tested by a comparison
   input wire logic [WORD_W-1:0] i_accum1, // first accumulator
   input wire logic [WORD_W-1:0] i_accum2, // second accumulator
   input wire logic [WORD_W:0] i_arith_sum, // arithmetic result, one guard bit
   input wire logic [WORD_W-1:0] i_result, // logic or negate result word
   input wire logic i_shift_out, // last bit shifted out
   output logic o_cond_code_low, // low condition code
   output logic o_cond_code_high, // high condition code
   output logic o_arith_range_flag, // overflow flag
   output logic o_logic_result_bit, // logic result bit
   output logic o_jump_if_result_set, // jump taken on result bit
   output logic o_jump_on_zero_code, // both codes zero
   output logic o_jump_on_nonzero_code, // any code set
   output logic o_jump_on_plus_code, // high 1, low 0
   output logic o_jump_on_minus_code, // high 0, low 1
   output logic o_jump_on_range_flag // overflow set
);

   // three flags only, codes as {high,low}
   logic [1:0] cc; // RULE13
   logic ov;
   logic logic_result_bit;

   // code of a signed 16-bit word: zero, minus or plus
   function automatic logic [1:0] sign_code(input logic [WORD_W-1:0] w);
      if (w == `CCG_WORD_ZERO)
         return `CCG_CC_ZERO;
      else if (w[WORD_W-1])
         return `CCG_CC_MINUS;
      else
         return `CCG_CC_PLUS;
   endfunction : sign_code

   // comparison of accum2 against accum1, signed
   wire logic cmp_eq = (i_accum2 == i_accum1);
   wire logic cmp_lt = ($signed(i_accum2) < $signed(i_accum1));
   wire logic [1:0] cmp_cc = cmp_eq ? `CCG_CC_ZERO :
                             (cmp_lt ? `CCG_CC_MINUS : `CCG_CC_PLUS); // RULE1
   logic rel_hit;
   always_comb begin
      unique case (i_rel)
         CCG_REL_EQ: rel_hit = cmp_eq;
         CCG_REL_NE: rel_hit = !cmp_eq;
         CCG_REL_GT: rel_hit = !cmp_eq && !cmp_lt;
         CCG_REL_LT: rel_hit = cmp_lt;
         CCG_REL_GE: rel_hit = !cmp_lt;
         CCG_REL_LE: rel_hit = cmp_lt || cmp_eq;
         default: rel_hit = 1'b0;
      endcase
   end

   // arithmetic: 17-bit signed sum; overflow when guard and sign differ
   wire logic ar_ovf = i_arith_sum[WORD_W] ^ i_arith_sum[WORD_W-1];
   wire logic ar_both_lim = ar_ovf && (i_arith_sum[WORD_W-1:0] == `CCG_WORD_ZERO);
   // low word zero under overflow only for -65536: both codes 0
   wire logic [1:0] ar_cc = !ar_ovf ? sign_code(i_arith_sum[WORD_W-1:0]) : // RULE5
                            ar_both_lim ? `CCG_CC_ZERO :                  // RULE6
                            (i_arith_sum[WORD_W] ? `CCG_CC_PLUS : `CCG_CC_MINUS); // RULE6

   // logic op: zero or nonzero only, never minus
   wire logic [1:0] lg_cc = (i_result == `CCG_WORD_ZERO) ? `CCG_CC_ZERO : `CCG_CC_PLUS; // RULE7
   wire logic [1:0] sh_cc = i_shift_out ? `CCG_CC_PLUS : `CCG_CC_ZERO; // RULE9
   // negate: 8000 negates to itself, the only overflow case
   wire logic ng_ov = (i_result == `CCG_WORD_MINLIM); // RULE12
   wire logic [1:0] ng_cc = sign_code(i_result); // RULE11

   // next flag values per operation class
   logic [1:0] next_cc;
   logic next_ov;
   logic next_rlo;
   always_comb begin
      next_cc = cc;
      next_ov = ov;
      next_rlo = logic_result_bit;
      if (i_op_valid) begin
         unique case (i_op)
            CCG_OP_CMP: begin
               next_cc = cmp_cc; // RULE1 RULE2
               next_rlo = rel_hit; // RULE3
            end
            CCG_OP_ARITH: begin
               next_cc = ar_cc;
               next_ov = ar_ovf; // RULE5 RULE6
            end
            CCG_OP_LOGIC: next_cc = lg_cc; // RULE8
            CCG_OP_SHIFT: next_cc = sh_cc; // RULE10
            CCG_OP_NEG: begin
               next_cc = ng_cc;
               next_ov = ng_ov; // RULE11 RULE12
            end
            CCG_OP_ADDK: next_cc = cc; // RULE15
            CCG_OP_NONE: next_cc = cc;
            default: next_cc = cc;
         endcase
      end
   end

   // flag register
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         cc <= `CCG_CC_ZERO;
         ov <= 1'b0;
         logic_result_bit <= 1'b0;
      end else begin
         cc <= next_cc;
         ov <= next_ov;
         logic_result_bit <= next_rlo;
      end
   end

   // flag outputs and jump decode, all from the flag register
   assign o_cond_code_low = cc[0];
   assign o_cond_code_high = cc[1];
   assign o_arith_range_flag = ov;
   assign o_logic_result_bit = logic_result_bit;
   assign o_jump_if_result_set = logic_result_bit; // RULE4
   assign o_jump_on_zero_code = (cc == `CCG_CC_ZERO); // RULE16
   assign o_jump_on_nonzero_code = (cc != `CCG_CC_ZERO); // RULE16
   assign o_jump_on_plus_code = (cc == `CCG_CC_PLUS); // RULE16
   assign o_jump_on_minus_code = (cc == `CCG_CC_MINUS); // RULE16
   assign o_jump_on_range_flag = ov; // RULE16

   // compare outcome lands in the codes one edge later
   AST_CMP_CODES: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE1
      (i_op_valid && i_op == CCG_OP_CMP) |=> (cc == $past(cmp_cc)))
      else $error("compare codes wrong");
   AST_CMP_KEEP_OV: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE2
      (i_op_valid && i_op == CCG_OP_CMP) |=> $stable(ov))
      else $error("compare changed overflow");
   AST_CMP_RLO: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE3
      (i_op_valid && i_op == CCG_OP_CMP && i_rel == CCG_REL_EQ && cmp_eq) |=> logic_result_bit)
      else $error("equal compare did not set result bit");
   AST_JC: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE4
      (i_op_valid && i_op == CCG_OP_CMP) |=> (o_jump_if_result_set == $past(rel_hit)))
      else $error("result jump does not follow compare");
   AST_AR_OK: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE5
      (i_op_valid && i_op == CCG_OP_ARITH && !ar_ovf && i_arith_sum[WORD_W])
      |=> (cc == `CCG_CC_MINUS && !ov))
      else $error("negative in-range sum codes wrong");
   AST_AR_OVF: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE6
      (i_op_valid && i_op == CCG_OP_ARITH && ar_ovf && !i_arith_sum[WORD_W])
      |=> (cc == `CCG_CC_MINUS && ov))
      else $error("positive overflow codes wrong");
   AST_LOGIC: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE8
      (i_op_valid && (i_op == CCG_OP_LOGIC || i_op == CCG_OP_SHIFT))
      |=> (ov == $past(ov) && cc[0] == 1'b0))
      else $error("logic or shift altered overflow or set low code");
   AST_NEG_MIN: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE12
      (i_op_valid && i_op == CCG_OP_NEG && i_result == `CCG_WORD_MINLIM)
      |=> (cc == `CCG_CC_MINUS && ov))
      else $error("negating minimum gave wrong flags");
   AST_ADDK: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE15
      (i_op_valid && i_op == CCG_OP_ADDK) |=> ($stable(cc) && $stable(ov) && $stable(logic_result_bit)))
      else $error("add constant changed flags");
   AST_JDEC: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE16
      o_jump_on_zero_code != o_jump_on_nonzero_code)
      else $error("zero and nonzero jump agree");

   // remaining classes: checked from inputs, not from the decode wires above
   AST_AR_ZERO: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE5
      (i_op_valid && i_op == CCG_OP_ARITH && i_arith_sum[WORD_W-1:0] == `CCG_WORD_ZERO
      && !i_arith_sum[WORD_W]) |=> (cc == `CCG_CC_ZERO && !ov))
      else $error("zero sum codes wrong");
   AST_AR_UNDER: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE6
      (i_op_valid && i_op == CCG_OP_ARITH && i_arith_sum[WORD_W] && !i_arith_sum[WORD_W-1]
      && i_arith_sum[WORD_W-1:0] != `CCG_WORD_ZERO) |=> (cc == `CCG_CC_PLUS && ov))
      else $error("negative overflow codes wrong");
   AST_AR_LIM: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE6
      (i_op_valid && i_op == CCG_OP_ARITH && i_arith_sum[WORD_W]
      && i_arith_sum[WORD_W-1:0] == `CCG_WORD_ZERO) |=> (cc == `CCG_CC_ZERO && ov))
      else $error("sum of both limits codes wrong");
   AST_LOGIC_CODE: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE7
      (i_op_valid && i_op == CCG_OP_LOGIC) |=> (cc[1] == (|$past(i_result)) && !cc[0]))
      else $error("logic codes do not follow result word");
   AST_SHIFT_CODE: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE9
      (i_op_valid && i_op == CCG_OP_SHIFT) |=> (cc[1] == $past(i_shift_out) && !cc[0]))
      else $error("shift codes do not follow last bit out");
   AST_SHIFT_KEEP_OV: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE10
      (i_op_valid && i_op == CCG_OP_SHIFT) |=> $stable(ov))
      else $error("shift changed overflow");
   AST_NEG_ZERO: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE11
      (i_op_valid && i_op == CCG_OP_NEG && i_result == `CCG_WORD_ZERO)
      |=> (cc == `CCG_CC_ZERO && !ov))
      else $error("negate of zero flags wrong");
   AST_NEG_SIGN: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE11
      (i_op_valid && i_op == CCG_OP_NEG && i_result != `CCG_WORD_MINLIM
      && i_result != `CCG_WORD_ZERO) |=> (!ov && cc[0] == $past(i_result[WORD_W-1])
      && cc[1] == !$past(i_result[WORD_W-1])))
      else $error("negate sign codes wrong");
   AST_KEEP_RLO: assert property (@(posedge i_mclk) disable iff (i_srst) // RULE3
      (i_op_valid && i_op != CCG_OP_CMP) |=> $stable(logic_result_bit))
      else $error("non-compare changed result bit");

endmodule : ccg_flags

// [tb/ccg_dpath_model.sv]
/* partner model: execution datapath results feeding the flag block.
   assumes operands come straight from the bench, no pipeline. */
`timescale 1ns/1ns
module ccg_dpath_model
   import ccg_pkg::*;
(
   input wire ccg_op_t i_op, // operation class
   input wire logic [15:0] i_a, // first accumulator
   input wire logic [15:0] i_b, // second accumulator
   output logic [16:0] o_sum, // sign-extended sum
   output logic [15:0] o_word // logic or negate word
);
   // negate hands over the negated word, not the operand
   assign o_sum = {i_a[15], i_a} + {i_b[15], i_b};
   assign o_word = (i_op == CCG_OP_NEG) ? 16'h0000 - i_a : i_a & i_b;
endmodule : ccg_dpath_model

// [tb/condition_code_generator_tb.sv]
/* self-checking bench of the flag block: corner cases, then random ops.
   assumes the flag block answers at the edge that takes the operation. */
`timescale 1ns/1ns
module condition_code_generator_tb
   import ccg_pkg::*;
;
   logic i_mclk = 1'b0, i_srst = 1'b1, v = 1'b0, so = 1'b0;
   ccg_op_t op = CCG_OP_NONE;
   ccg_rel_t rel = CCG_REL_EQ;
   logic [15:0] a = 16'h0000, b = 16'h0000, word;
   logic [16:0] sum;
   wire [9:0] o;
   logic lo = 1'b0, hi = 1'b0, ov = 1'b0, rb = 1'b0;
   int miscompares = 0, checks_done = 0, cyc = 0;
   integer seed = 32'h2e1df7b4;
   always #10 i_mclk = ~i_mclk;
   ccg_dpath_model dm_u(.i_op(op), .i_a(a), .i_b(b), .o_sum(sum), .o_word(word));
   ccg_flags dut_u(.i_mclk(i_mclk), .i_srst(i_srst), .i_op_valid(v), .i_op(op), .i_rel(rel),
      .i_accum1(a), .i_accum2(b), .i_arith_sum(sum), .i_result(word), .i_shift_out(so),
      .o_cond_code_low(o[9]), .o_cond_code_high(o[8]), .o_arith_range_flag(o[7]),
      .o_logic_result_bit(o[6]), .o_jump_if_result_set(o[5]), .o_jump_on_zero_code(o[4]),
      .o_jump_on_nonzero_code(o[3]), .o_jump_on_plus_code(o[2]),
      .o_jump_on_minus_code(o[1]), .o_jump_on_range_flag(o[0]));
   // relation of second accumulator against first, signed
   function logic rel_ok(input ccg_rel_t r, input logic signed [15:0] p, q);
      return r == CCG_REL_EQ ? p == q : r == CCG_REL_NE ? p != q : r == CCG_REL_GT ? p > q :
         r == CCG_REL_LT ? p < q : r == CCG_REL_GE ? p >= q : r == CCG_REL_LE ? p <= q : 1'b0;
   endfunction : rel_ok
   task final_report;
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   // one compare covers flags and every jump decode
   task chk;
      logic [9:0] e;
      e = {lo, hi, ov, rb, rb, ~hi & ~lo, hi | lo, hi & ~lo, ~hi & lo, ov};
      checks_done++;
      if (o !== e) begin
         miscompares++;
         $display("mismatch %0t flags %b expected %b", $time, o, e);
      end
   endtask : chk
   // drive at an edge, take at the next; a held valid retakes the same op harmlessly
   task step(input ccg_op_t p, input ccg_rel_t r, input logic [15:0] x, y, input logic s, vv);
      logic signed [16:0] t;
      logic [15:0] w;
      @(posedge i_mclk);
      op <= p; rel <= r; a <= x; b <= y; so <= s; v <= vv;
      t = $signed({x[15], x}) + $signed({y[15], y});
      w = 16'h0000 - x;
      if (vv) case (p)
         CCG_OP_CMP: begin
            {hi, lo} = (x == y) ? 2'h0 : ($signed(y) < $signed(x)) ? 2'h1 : 2'h2;
            rb = rel_ok(r, y, x);
         end
         CCG_OP_ARITH: begin
            ov = (t < -32768) || (t > 32767);
            {hi, lo} = (t == 0 || t == -65536) ? 2'h0 : (t < -32768) ? 2'h2 :
               (t < 0 || t > 32767) ? 2'h1 : 2'h2;
         end
         CCG_OP_LOGIC: {hi, lo} = {|(x & y), 1'b0};
         CCG_OP_SHIFT: {hi, lo} = {s, 1'b0};
         CCG_OP_NEG: begin
            ov = (w == 16'h8000);
            {hi, lo} = (w == 16'h0000) ? 2'h0 : w[15] ? 2'h1 : 2'h2;
         end
         default: ;
      endcase
      @(posedge i_mclk);
      #1 chk();
   endtask : step
   // ceiling well above the few hundred steps below
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         final_report();
      end
   end
   initial begin
      logic [31:0] r1, r2;
      repeat (5) @(posedge i_mclk);
      i_srst <= 1'b0;
      #1 chk();
      step(CCG_OP_ARITH, CCG_REL_EQ, 16'h8000, 16'h8000, 1'b0, 1'b1);
      step(CCG_OP_CMP, CCG_REL_GT, 16'h0003, 16'h0005, 1'b0, 1'b1);
      step(CCG_OP_ARITH, CCG_REL_EQ, 16'h7fff, 16'h0001, 1'b0, 1'b1);
      step(CCG_OP_SHIFT, CCG_REL_EQ, 16'h0000, 16'h0000, 1'b1, 1'b1);
      step(CCG_OP_ARITH, CCG_REL_EQ, 16'h8000, 16'hffff, 1'b0, 1'b1);
      step(CCG_OP_LOGIC, CCG_REL_EQ, 16'h00f0, 16'h0f00, 1'b0, 1'b1);
      step(CCG_OP_ADDK, CCG_REL_EQ, 16'h1234, 16'hffff, 1'b1, 1'b1);
      step(CCG_OP_NEG, CCG_REL_EQ, 16'h8000, 16'h0000, 1'b0, 1'b1);
      // mid-run reset with flags set; valid dropped so nothing is retaken after release
      @(posedge i_mclk);
      i_srst <= 1'b1;
      v <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_srst <= 1'b0;
      {lo, hi, ov, rb} = 4'h0;
      #1 chk();
      step(CCG_OP_NEG, CCG_REL_EQ, 16'h0000, 16'h0000, 1'b0, 1'b1);
      step(CCG_OP_ARITH, CCG_REL_EQ, 16'h8000, 16'h0000, 1'b0, 1'b1);
      step(CCG_OP_ARITH, CCG_REL_EQ, 16'h0001, 16'hffff, 1'b0, 1'b1);
      for (int k = 0; k < 18; k++)
         step(CCG_OP_CMP, ccg_rel_t'(k % 6), 16'h0003, k < 6 ? 16'h0005 : k < 12 ?
            16'h0003 : 16'hfffd, 1'b0, 1'b1);
      repeat (400) begin
         r1 = $random(seed);
         r2 = $random(seed);
         step(ccg_op_t'(r1[2:0] % 3'h7), ccg_rel_t'(r1[5:3] % 3'h6), r2[15:0], r2[31:16],
            r1[6], r1[7] | r1[8]);
      end
      final_report();
   end
endmodule : condition_code_generator_tb
